// File: pkg/rtsr_cfg_if.sv
// rtsr_cfg_if: snapshot of run-time settings passed to the byte formatter
// assumes: one producer (top) and one consumer (formatter) on the same clock
`timescale 1ns/1ps
interface rtsr_cfg_if;
    logic [7:0] chip_len;   // chip settings area length
    logic [7:0] pin_len;    // general_purpose_pin settings area length
    logic       serial_en;  // serial-number enable
    logic [1:0] sec_mode;   // protection mode
    logic [4:0] clk_field;  // duty [4:3], divider [2:0]
    logic [1:0] vref_lvl;   // internal_dac_reference level
    logic       vref_src;   // 1 internal reference, 0 supply
    logic [4:0] dac_code;   // power-up dac code

    // producer drives, consumer reads
    modport src (output chip_len, pin_len, serial_en, sec_mode, clk_field, vref_lvl, vref_src, dac_code);
    modport dst (input  chip_len, pin_len, serial_en, sec_mode, clk_field, vref_lvl, vref_src, dac_code);
endinterface

// File: pkg/rtsr_pkg.sv
// rtsr_pkg: constants shared by the run-time settings readback block
// assumes: 32-bit AHB-Lite register bus, byte-wide response stream
package rtsr_pkg;

    // command codes and status
    localparam logic [7:0] RTSR_CMD_READ_SETTINGS = 8'h61; // settings-read request code
    localparam logic [7:0] RTSR_STATUS_OK         = 8'h00; // command completed

    // response layout
    localparam int         RTSR_IDX_W     = 6;              // byte index width (64-byte report)
    localparam logic [5:0] RTSR_BYTE_ECHO = 6'h00;          // command echo
    localparam logic [5:0] RTSR_BYTE_STAT = 6'h01;          // completion status
    localparam logic [5:0] RTSR_BYTE_CLEN = 6'h02;          // chip area length
    localparam logic [5:0] RTSR_BYTE_GLEN = 6'h03;          // pin area length
    localparam logic [5:0] RTSR_BYTE_SEC  = 6'h04;          // serial enable and protection
    localparam logic [5:0] RTSR_BYTE_CLK  = 6'h05;          // clock-output field
    localparam logic [5:0] RTSR_BYTE_DAC  = 6'h06;          // dac reference and power-up value
    localparam logic [5:0] RTSR_BYTE_LAST = 6'h06;          // last byte this block produces

    // protection mode encodings
    localparam logic [1:0] RTSR_SEC_OPEN   = 2'h0;          // unsecured
    localparam logic [1:0] RTSR_SEC_PASSWD = 2'h1;          // password protected
    localparam logic [1:0] RTSR_SEC_LOCKED = 2'h2;          // permanently locked

    // dac reference level encodings
    localparam logic [1:0] RTSR_VREF_OFF  = 2'h0;           // internal reference off
    localparam logic [1:0] RTSR_VREF_1V0  = 2'h1;           // 1.024 V
    localparam logic [1:0] RTSR_VREF_2V0  = 2'h2;           // 2.048 V
    localparam logic [1:0] RTSR_VREF_4V0  = 2'h3;           // 4.096 V

    // register byte offsets
    localparam logic [7:0] RTSR_OFS_CHIP  = 8'h00;          // chip_config
    localparam logic [7:0] RTSR_OFS_DAC   = 8'h04;          // dac_config
    localparam logic [7:0] RTSR_OFS_AREA  = 8'h08;          // area_length
    localparam logic [7:0] RTSR_OFS_STAT  = 8'h0C;          // readback_status (read only)

    // chip_config fields
    localparam int RTSR_F_SEC_LO  = 0;                      // protection mode [1:0]
    localparam int RTSR_F_SERIAL  = 7;                      // serial-number enable
    localparam int RTSR_F_CLK_LO  = 8;                      // clock-output field [12:8]
    // dac_config fields
    localparam int RTSR_F_DVAL_LO = 0;                      // power-up dac code [4:0]
    localparam int RTSR_F_DSRC    = 5;                      // reference source
    localparam int RTSR_F_DLVL_LO = 6;                      // reference level [7:6]
    // area_length fields
    localparam int RTSR_F_CLEN_LO = 0;                      // chip area length [7:0]
    localparam int RTSR_F_GLEN_LO = 8;                      // pin area length [15:8]
    // readback_status fields
    localparam int RTSR_F_BUSY    = 0;                      // response in progress
    localparam int RTSR_F_CNT_LO  = 8;                      // responses served [15:8]

    // reset values
    localparam logic [31:0] RTSR_RST_CHIP = 32'h0000_0000;  // open, no serial, clock field 0
    localparam logic [31:0] RTSR_RST_DAC  = 32'h0000_0000;  // reference off, supply, code 0
    localparam logic [31:0] RTSR_RST_AREA = 32'h0000_0000;  // lengths zero until firmware sets them

    // ahb-lite encodings
    localparam logic [1:0] RTSR_HTRANS_NONSEQ = 2'h2;       // nonsequential
    localparam logic [1:0] RTSR_HTRANS_SEQ    = 2'h3;       // sequential
    localparam logic       RTSR_HRESP_OKAY    = 1'h0;       // okay response

    // sequencer states
    typedef enum logic [1:0] {
        RTSR_IDLE,
        RTSR_SEND,
        RTSR_DRAIN
    } rtsr_state_t;

endpackage

// File: src/rtsr_byte_fmt.sv
// rtsr_byte_fmt: builds one response byte from the settings snapshot
// assumes: index and snapshot are stable registers; output is combinational
`timescale 1ns/1ps
module rtsr_byte_fmt
    import rtsr_pkg::*;
(
    // settings snapshot
    rtsr_cfg_if.dst                  cfg,
    // byte select and result
    input  wire logic [RTSR_IDX_W-1:0] index,
    output logic      [7:0]            data
);

    // byte mux; bits not listed read as zero
    always_comb begin
        data = 8'h00;
        case (index)
            RTSR_BYTE_ECHO: data = RTSR_CMD_READ_SETTINGS;
            RTSR_BYTE_STAT: data = RTSR_STATUS_OK;
            RTSR_BYTE_CLEN: data = cfg.chip_len;
            RTSR_BYTE_GLEN: data = cfg.pin_len;
            RTSR_BYTE_SEC: begin
                data[7]   = cfg.serial_en;
                data[1:0] = cfg.sec_mode;
            end
            RTSR_BYTE_CLK: begin
                data[4:3] = cfg.clk_field[4:3];
                data[2:0] = cfg.clk_field[2:0];
            end
            RTSR_BYTE_DAC: begin
                data[7:6] = cfg.vref_lvl;
                data[5]   = cfg.vref_src;
                data[4:0] = cfg.dac_code;
            end
            default: data = 8'h00;
        endcase
    end

endmodule // rtsr_byte_fmt

// File: src/rtsr_top.sv
// rtsr_top: answers the settings-read request with the run-time settings bytes 0..6
// assumes: request and response streams are on mclk; firmware loads settings over ahb-lite
//
// Summary of operation
// - request code 0x61 starts run-time settings reply
// - byte 0 echoes code, byte 1 zero
// - byte 2 holds chip area length
// - byte 3 holds pin area length
// - byte 4 bit 7 serial-number enable
// - byte 4 bits 1-0 protection mode
// - byte 5 bits 4-0 clock-output setting
// - clock field: duty upper, divider lower
// - byte 6 bits 7-6 reference level
// - byte 6 bit 5 reference source
// - byte 6 bits 4-0 power-up code
//
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module rtsr_top
    import rtsr_pkg::*;
(
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  srst,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // request from the report endpoint
    input  wire logic                  cmd_valid,
    input  wire logic [7:0]            cmd_code,
    output logic                       cmd_busy,
    // response byte stream
    output logic                       resp_valid,
    output logic [RTSR_IDX_W-1:0]      resp_index,
    output logic [7:0]                 resp_data,
    output logic                       resp_last,
    input  wire logic                  resp_ready
);

    // ---------------- register file state ----------------
    logic [31:0] chip_config;        // serial enable, protection, clock field
    logic [31:0] dac_config;         // reference level, source, power-up code
    logic [31:0] area_length;        // area lengths
    logic [7:0]  served_count;       // completed responses, wraps
    logic [31:0] next_chip_config;   // next chip_config
    logic [31:0] next_dac_config;    // next dac_config
    logic [31:0] next_area_length;   // next area_length

    // ahb data-phase bookkeeping
    logic        wr_pend;            // a write data phase is due
    logic [7:0]  wr_addr;            // its byte offset
    logic        next_wr_pend;       // next wr_pend
    logic [7:0]  next_wr_addr;       // next wr_addr
    logic [31:0] next_hrdata;        // next read data
    logic        addr_ok;            // address phase taken this cycle
    logic        mapped;             // word-aligned offset in the low 256 bytes

    // ---------------- sequencer state ----------------
    rtsr_state_t             state;        // sequencer state
    rtsr_state_t             next_state;   // next state
    logic [RTSR_IDX_W-1:0]   idx;          // byte about to be presented
    logic [RTSR_IDX_W-1:0]   next_idx;     // next idx
    logic                    next_resp_valid;
    logic [RTSR_IDX_W-1:0]   next_resp_index;
    logic [7:0]              next_resp_data;
    logic                    next_resp_last;
    logic                    next_cmd_busy;
    logic [7:0]              next_served_count;
    logic                    snap_load;    // capture settings into snapshot
    logic [7:0]              fmt_data;     // formatter output for idx

    // settings snapshot, held steady for the whole response
    rtsr_cfg_if snap ();

    // ---------------- ahb-lite slave, next values ----------------
    // zero-wait slave: writes land in the data phase, reads are computed in the
    // address phase from the next register values so a write just before a read
    // is already visible
    always_comb begin
        addr_ok          = hsel && hready && (htrans == RTSR_HTRANS_NONSEQ || htrans == RTSR_HTRANS_SEQ);
        next_chip_config = chip_config;
        next_dac_config  = dac_config;
        next_area_length = area_length;
        // data phase of a write: store into the selected register
        if (wr_pend) begin
            case (wr_addr)
                RTSR_OFS_CHIP: begin
                    next_chip_config = 32'h0000_0000;
                    next_chip_config[RTSR_F_SERIAL] = hwdata[RTSR_F_SERIAL];
                    next_chip_config[RTSR_F_SEC_LO +: 2] = hwdata[RTSR_F_SEC_LO +: 2];
                    next_chip_config[RTSR_F_CLK_LO +: 5] = hwdata[RTSR_F_CLK_LO +: 5];
                end
                RTSR_OFS_DAC: begin
                    next_dac_config = 32'h0000_0000;
                    next_dac_config[RTSR_F_DLVL_LO +: 2] = hwdata[RTSR_F_DLVL_LO +: 2];
                    next_dac_config[RTSR_F_DSRC] = hwdata[RTSR_F_DSRC];
                    next_dac_config[RTSR_F_DVAL_LO +: 5] = hwdata[RTSR_F_DVAL_LO +: 5];
                end
                RTSR_OFS_AREA: begin
                    next_area_length = 32'h0000_0000;
                    next_area_length[RTSR_F_CLEN_LO +: 8] = hwdata[RTSR_F_CLEN_LO +: 8];
                    next_area_length[RTSR_F_GLEN_LO +: 8] = hwdata[RTSR_F_GLEN_LO +: 8];
                end
                default: ;   // status and unmapped offsets ignore writes
            endcase
        end
        // address phase: latch write target, or fetch read data
        next_wr_pend = addr_ok && hwrite;
        next_wr_addr = haddr[7:0];
        mapped       = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
        next_hrdata  = 32'h0000_0000;
        if (addr_ok && !hwrite && mapped) begin
            case (haddr[7:0])
                RTSR_OFS_CHIP: next_hrdata = next_chip_config;
                RTSR_OFS_DAC:  next_hrdata = next_dac_config;
                RTSR_OFS_AREA: next_hrdata = next_area_length;
                RTSR_OFS_STAT: begin
                    next_hrdata[RTSR_F_BUSY] = cmd_busy;
                    next_hrdata[RTSR_F_CNT_LO +: 8] = served_count;
                end
                default: next_hrdata = 32'h0000_0000;   // unmapped reads zero
            endcase
        end
        if (!mapped) begin
            next_wr_pend = 1'b0;   // unmapped writes are dropped
        end
    end

    // ---------------- ahb-lite slave, registers ----------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            chip_config <= RTSR_RST_CHIP;
            dac_config  <= RTSR_RST_DAC;
            area_length <= RTSR_RST_AREA;
            wr_pend     <= 1'b0;
            wr_addr     <= 8'h00;
            hrdata      <= 32'h0000_0000;
            hreadyout   <= 1'b1;
            hresp       <= RTSR_HRESP_OKAY;
        end else begin
            chip_config <= next_chip_config;
            dac_config  <= next_dac_config;
            area_length <= next_area_length;
            wr_pend     <= next_wr_pend;
            wr_addr     <= next_wr_addr;
            hrdata      <= next_hrdata;
            hreadyout   <= 1'b1;              // never inserts wait states
            hresp       <= RTSR_HRESP_OKAY;   // every transfer answers okay
        end
    end

    // ---------------- settings snapshot ----------------
    // taken when a request is accepted so a firmware write mid-response
    // cannot tear the report
    always_ff @(posedge mclk) begin
        if (srst) begin
            snap.chip_len  <= 8'h00;
            snap.pin_len   <= 8'h00;
            snap.serial_en <= 1'b0;
            snap.sec_mode  <= RTSR_SEC_OPEN;
            snap.clk_field <= 5'h00;
            snap.vref_lvl  <= RTSR_VREF_OFF;
            snap.vref_src  <= 1'b0;
            snap.dac_code  <= 5'h00;
        end else if (snap_load) begin
            snap.chip_len  <= area_length[RTSR_F_CLEN_LO +: 8];
            snap.pin_len   <= area_length[RTSR_F_GLEN_LO +: 8];
            snap.serial_en <= chip_config[RTSR_F_SERIAL];
            snap.sec_mode  <= chip_config[RTSR_F_SEC_LO +: 2];
            snap.clk_field <= chip_config[RTSR_F_CLK_LO +: 5];
            snap.vref_lvl  <= dac_config[RTSR_F_DLVL_LO +: 2];
            snap.vref_src  <= dac_config[RTSR_F_DSRC];
            snap.dac_code  <= dac_config[RTSR_F_DVAL_LO +: 5];
        end
    end

    // byte formatter for the current index
    rtsr_byte_fmt u_fmt (
        .cfg   (snap),
        .index (idx),
        .data  (fmt_data)
    );

    // ---------------- sequencer, next values ----------------
    // idle: accept the settings-read code; other codes belong to other handlers
    // send: present bytes 0..6, one per accepted handshake
    // drain: hold the last byte until it is taken
    always_comb begin
        next_state        = state;
        next_idx          = idx;
        next_resp_valid   = resp_valid;
        next_resp_index   = resp_index;
        next_resp_data    = resp_data;
        next_resp_last    = resp_last;
        next_cmd_busy     = cmd_busy;
        next_served_count = served_count;
        snap_load         = 1'b0;
        case (state)
            RTSR_IDLE: begin
                if (cmd_valid && cmd_code == RTSR_CMD_READ_SETTINGS) begin
                    snap_load     = 1'b1;
                    next_idx      = RTSR_BYTE_ECHO;
                    next_cmd_busy = 1'b1;
                    next_state    = RTSR_SEND;
                end
            end
            RTSR_SEND: begin
                // load a new byte when the stream is empty or the last one is taken
                if (!resp_valid || resp_ready) begin
                    next_resp_valid = 1'b1;
                    next_resp_index = idx;
                    next_resp_data  = fmt_data;
                    next_resp_last  = (idx == RTSR_BYTE_LAST);
                    next_idx        = idx + 6'h01;
                    if (idx == RTSR_BYTE_LAST) begin
                        next_state = RTSR_DRAIN;
                    end
                end
            end
            RTSR_DRAIN: begin
                if (resp_ready) begin
                    next_resp_valid   = 1'b0;
                    next_resp_last    = 1'b0;
                    next_cmd_busy     = 1'b0;
                    next_served_count = served_count + 8'h01;
                    next_state        = RTSR_IDLE;
                end
            end
            default: begin
                next_resp_valid = 1'b0;
                next_resp_last  = 1'b0;
                next_cmd_busy   = 1'b0;
                next_state      = RTSR_IDLE;
            end
        endcase
    end

    // ---------------- sequencer, registers ----------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            state        <= RTSR_IDLE;
            idx          <= RTSR_BYTE_ECHO;
            resp_valid   <= 1'b0;
            resp_index   <= RTSR_BYTE_ECHO;
            resp_data    <= 8'h00;
            resp_last    <= 1'b0;
            cmd_busy     <= 1'b0;
            served_count <= 8'h00;
        end else begin
            state        <= next_state;
            idx          <= next_idx;
            resp_valid   <= next_resp_valid;
            resp_index   <= next_resp_index;
            resp_data    <= next_resp_data;
            resp_last    <= next_resp_last;
            cmd_busy     <= next_cmd_busy;
            served_count <= next_served_count;
        end
    end

endmodule // rtsr_top

// File: verification/rtsr_chk.sv
// rtsr_chk: port checks on the request and reply stream of rtsr_top
// assumes: bound into rtsr_top, one mclk domain, srst synchronous
`timescale 1ns/1ps
module rtsr_chk
    import rtsr_pkg::*;
(
    // clock and reset
    input wire logic                  mclk,
    input wire logic                  srst,
    // request
    input wire logic                  cmd_valid,
    input wire logic [7:0]            cmd_code,
    input wire logic                  cmd_busy,
    // reply stream
    input wire logic                  resp_valid,
    input wire logic [RTSR_IDX_W-1:0] resp_index,
    input wire logic [7:0]            resp_data,
    input wire logic                  resp_last,
    input wire logic                  resp_ready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // request accepted in idle
    wire logic take = !cmd_busy && cmd_valid && cmd_code == RTSR_CMD_READ_SETTINGS;
    // a byte handed over this edge
    wire logic step = resp_valid && resp_ready;

    start_latency_a: assert property (take |=> cmd_busy ##1 (resp_valid && resp_index == 6'h00))
        else $error("reply not started two cycles after request");
    foreign_code_a: assert property (!cmd_busy && cmd_valid && !take |=> !cmd_busy)
        else $error("foreign code started a reply");
    echo_byte_a: assert property (resp_valid && resp_index == 6'h00 |-> resp_data == 8'h61)
        else $error("byte 0 not the echo");
    status_byte_a: assert property (resp_valid && resp_index == 6'h01 |-> resp_data == 8'h00)
        else $error("byte 1 not zero");
    sec_spare_a: assert property (resp_valid && resp_index == 6'h04 |-> resp_data[6:2] == 5'h00)
        else $error("byte 4 spare bits set");
    clk_spare_a: assert property (resp_valid && resp_index == 6'h05 |-> resp_data[7:5] == 3'h0)
        else $error("byte 5 spare bits set");
    byte_hold_a: assert property (resp_valid && !resp_ready |=> resp_valid && $stable(resp_data) && $stable(resp_index))
        else $error("byte changed before taken");
    index_step_a: assert property (step && !resp_last |=> resp_valid && resp_index == $past(resp_index) + 6'h01)
        else $error("index did not advance by one");
    last_flag_a: assert property (resp_valid |-> resp_last == (resp_index == 6'h06))
        else $error("last flag not with byte 6");
    reply_end_a: assert property (step && resp_last |=> !resp_valid && !cmd_busy)
        else $error("reply did not end after byte 6");

    // main scenarios
    cover property (take);
    cover property (resp_valid && !resp_ready ##1 step);
    cover property (step && resp_last);
endmodule // rtsr_chk

bind rtsr_top rtsr_chk u_chk (.mclk(mclk), .srst(srst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_busy(cmd_busy), .resp_valid(resp_valid), .resp_index(resp_index), .resp_data(resp_data),
    .resp_last(resp_last), .resp_ready(resp_ready));

// File: verification/rtsr_host_model.sv
// rtsr_host_model: report endpoint on the host side of rtsr_top
// assumes: same mclk as the design; tb_top drives it through send and stall
`timescale 1ns/1ps
module rtsr_host_model
    import rtsr_pkg::*;
(
    // clock
    input  wire logic                  mclk,
    // request out
    output logic                       cmd_valid,
    output logic [7:0]                 cmd_code,
    // reply in
    input  wire logic                  resp_valid,
    input  wire logic [RTSR_IDX_W-1:0] resp_index,
    input  wire logic [7:0]            resp_data,
    output logic                       resp_ready
);
    logic [7:0] rx [8];    // captured bytes by index
    int         rx_n;      // bytes taken since cleared
    logic       stall;     // 1 makes the consumer hold off at random
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'hA5;
        resp_ready = 1'b1;
        rx_n = 0;
        stall = 1'b0;
    end
    // take a byte when offered and ready, then pick the next ready
    always @(posedge mclk) begin
        if (resp_valid && resp_ready) begin
            rx[resp_index[2:0]] <= resp_data;
            rx_n <= rx_n + 1;
        end
        resp_ready <= stall ? ($urandom_range(2) != 0) : 1'b1;
    end
    // one-cycle request; the code line shows junk once released
    task automatic send(input logic [7:0] code);
        cmd_valid <= 1'b1;
        cmd_code  <= code;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        cmd_code  <= ~code;
    endtask
endmodule // rtsr_host_model

// File: verification/tb_top.sv
// tb_top: random and corner tests of rtsr_top over ahb-lite and the reply stream
// assumes: one slave, hready tied to hreadyout; host side is rtsr_host_model
`timescale 1ns/1ps
module tb_top
    import rtsr_pkg::*;
;
    logic                  mclk, srst, hsel, hwrite, hreadyout, hresp;
    logic [31:0]           haddr, hwdata, hrdata, rd, chip, dac, area, w;
    logic [1:0]            htrans;
    logic [2:0]            hsize;
    logic                  cmd_valid, cmd_busy, resp_valid, resp_last, resp_ready;
    logic [7:0]            cmd_code, resp_data;
    logic [RTSR_IDX_W-1:0] resp_index;
    logic [31:0]           msk [5] = '{32'h1F83, 32'hFF, 32'hFFFF, 32'h0, 32'h0};
    int                    err_count, n_checks, cyc, served;

    rtsr_top dut (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_busy(cmd_busy), .resp_valid(resp_valid), .resp_index(resp_index),
        .resp_data(resp_data), .resp_last(resp_last), .resp_ready(resp_ready));
    rtsr_host_model host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .resp_valid(resp_valid), .resp_index(resp_index), .resp_data(resp_data),
        .resp_ready(resp_ready));

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            stop_test();
        end
    end
    // compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one single ahb transfer; read data lands in rd
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= RTSR_HTRANS_NONSEQ;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check("bus response", hresp, 32'h0);
    endtask
    // expected reply byte from the settings loaded before the request
    function automatic logic [7:0] exp_byte(input int i);
        case (i)
            0: return 8'h61;
            1: return 8'h00;
            2: return area[7:0];
            3: return area[15:8];
            4: return {chip[7], 5'h00, chip[1:0]};
            5: return {3'h0, chip[12:8]};
            default: return dac[7:0];
        endcase
    endfunction
    // verdict
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        srst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        void'($urandom(53367));
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        // reset values, masks, read-only status and an unmapped word
        for (int a = 0; a < 5; a++) begin
            ahb(1'b0, 32'(4 * a), 32'h0);
            check("reset value", rd, 32'h0);
            w = $urandom;
            ahb(1'b1, 32'(4 * a), w);
            ahb(1'b0, 32'(4 * a), 32'h0);
            check("register bits", rd, w & msk[a]);
        end
        // every protection and reference code, random fields, stalls on odd passes
        for (int i = 0; i < 12; i++) begin
            chip = $urandom & 32'h1F83;
            chip[1:0] = 2'(i % 4);
            dac = $urandom & 32'hFF;
            dac[7:6] = 2'(i % 4);
            area = (i == 1) ? 32'hFFFF : $urandom & 32'hFFFF;
            ahb(1'b1, 32'h0, chip);
            ahb(1'b1, 32'h4, dac);
            ahb(1'b1, 32'h8, area);
            host.stall = i[0];
            host.rx_n = 0;
            host.send(8'h60 + 8'(2 * (i % 2)));
            @(posedge mclk);
            check("busy after foreign code", cmd_busy, 1'b0);
            host.send(RTSR_CMD_READ_SETTINGS);
            // late write and a request while busy must not disturb the reply
            ahb(1'b1, 32'h0, ~chip);
            // status shows the reply in progress, count not yet bumped
            ahb(1'b0, 32'hC, 32'h0);
            check("busy during reply", rd, {16'h0, served[7:0], 8'h01});
            host.send(RTSR_CMD_READ_SETTINGS);
            for (int k = 0; k < 100 && (cmd_busy || host.rx_n < 7); k++) @(posedge mclk);
            for (int k = 0; k < 7; k++) check("reply byte", host.rx[k], exp_byte(k));
            check("reply length", host.rx_n, 7);
            served++;
            ahb(1'b0, 32'hC, 32'h0);
            check("replies served", rd, {16'h0, served[7:0], 8'h00});
        end
        stop_test();
    end
endmodule // tb_top
